// ### logic/spc_event_counter.sv
// One filtered event counter channel
`timescale 1ns/1ps
module spc_event_counter
  import spc_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  input  wire spc_chan_cfg_s    cfg,
  input  wire spc_events_s      events,
  input  wire logic [2:0]       burst_log2,
  output logic      [WIDTH-1:0] count
);

  if (WIDTH != 32)
  begin : g_bad_width
    $error("spc_event_counter: WIDTH must be 32");
  end

  logic [7:0]       ev_master;
  logic             ev_to_regs;
  logic             master_ok;
  logic             region_ok;
  logic             code_ok;
  logic             filters_off;
  logic [16:0]      burst_mask;
  logic [16:0]      rounded;
  logic [16:0]      pieces;
  logic [WIDTH-1:0] step;
  logic [WIDTH-1:0] next_count;

  assign ev_master   = (cfg.event_type == SPC_EV_ELEVATE)
                     ? events.elevate_master : events.cmd_master;
  assign ev_to_regs  = (cfg.event_type == SPC_EV_ELEVATE)
                     ? events.elevate_to_regs : events.cmd_to_regs;
  assign filters_off = !cfg.master_en && !cfg.region_en;

  // Identity filter
  assign master_ok = !cfg.master_en || (ev_master == cfg.master_id);

  // Region filter
  assign region_ok = !cfg.region_en
    || ((cfg.region_sel == SPC_REGION_SDRAM) && !ev_to_regs)
    || ((cfg.region_sel == SPC_REGION_REGS) && ev_to_regs);

  // Legal code and filter combinations
  always_comb
  begin
    case (cfg.event_type)
      SPC_EV_ACCESS:   code_ok = !cfg.region_en;
      SPC_EV_ACTIVATE: code_ok = filters_off;
      SPC_EV_READ:     code_ok = 1'b1;
      SPC_EV_WRITE:    code_ok = 1'b1;
      SPC_EV_QFULL:    code_ok = filters_off;
      SPC_EV_ELEVATE:  code_ok = 1'b1;
      SPC_EV_PENDING:  code_ok = filters_off;
      default:         code_ok = 1'b0;
    endcase
  end

  // Transfer split into default-burst pieces, rounded up
  assign burst_mask = 17'((17'h0_0001 << burst_log2) - 17'h0_0001);
  assign rounded    = 17'({1'b0, events.cmd_bytes} + burst_mask);
  assign pieces     = rounded >> burst_log2;

  always_comb
  begin
    step = '0;
    case (cfg.event_type)
      SPC_EV_ACCESS:
        if (events.cmd_valid)
          step = WIDTH'(pieces);
      SPC_EV_READ:
        if (events.cmd_valid && !events.cmd_write)
          step = WIDTH'(pieces);
      SPC_EV_WRITE:
        if (events.cmd_valid && events.cmd_write)
          step = WIDTH'(pieces);
      SPC_EV_ACTIVATE:
        step = WIDTH'(events.activate);
      SPC_EV_QFULL:
        step = WIDTH'(events.queue_full);
      SPC_EV_ELEVATE:
        step = WIDTH'(events.elevate);
      SPC_EV_PENDING:
        step = WIDTH'(events.queue_pending);
      default:
        step = '0;
    endcase
    if (!(code_ok && master_ok && region_ok))
      step = '0;
  end

  assign next_count = count + step;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= '0;
    else if (clk_en)
      count <= next_count;
  end

endmodule : spc_event_counter

// ### logic/spc_perf_counters.sv
// Performance counter unit with AHB-Lite register slave
`timescale 1ns/1ps
module spc_perf_counters
  import spc_pkg::*;
#(
  parameter int CHANNELS = 2
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire spc_events_s events,
  input  wire logic [2:0]  burst_log2
);

  if (CHANNELS != 2)
  begin : g_bad_channels
    $error("spc_perf_counters: CHANNELS must be 2");
  end

  logic [31:0]   config_reg;
  logic [31:0]   select_reg;
  logic [31:0]   elapsed;
  logic [31:0]   counts [CHANNELS];
  spc_chan_cfg_s chan_cfg [CHANNELS];

  logic          accept;
  logic          wr_pend;
  logic [11:0]   wr_addr;
  logic          hit_count_one;
  logic          hit_count_two;
  logic          hit_config;
  logic          hit_select;
  logic          hit_elapsed;
  logic [31:0]   rd_data;
  logic          wr_config;
  logic          wr_select;
  logic [31:0]   next_config;
  logic [31:0]   next_select;

  // Channel field extraction and counters
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_chan
      localparam int B = gi * SPC_CH_STRIDE;

      assign chan_cfg[gi].master_en  = config_reg[B + SPC_CFG_MST_EN_POS];
      assign chan_cfg[gi].region_en  = config_reg[B + SPC_CFG_REG_EN_POS];
      assign chan_cfg[gi].event_type =
        config_reg[B + SPC_CFG_TYPE_POS +: 4];
      assign chan_cfg[gi].master_id  =
        select_reg[B + SPC_SEL_MST_POS +: 8];
      assign chan_cfg[gi].region_sel =
        select_reg[B + SPC_SEL_REG_POS +: 4];

      spc_event_counter #(
        .WIDTH      (32)
      ) u_counter (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clk_en     (clk_en),
        .cfg        (chan_cfg[gi]),
        .events     (events),
        .burst_log2 (burst_log2),
        .count      (counts[gi])
      );
    end
  endgenerate

  // Elapsed cycle counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      elapsed <= SPC_COUNT_RESET;
    else if (clk_en)
      elapsed <= elapsed + 32'h0000_0001;
  end

  // Bus stalls while the unit is frozen
  assign hreadyout = clk_en;
  assign hresp     = 1'b0;
  assign accept    = hsel && htrans[1] && hready && clk_en;

  // Read address decode
  assign hit_count_one = (haddr[11:0] == SPC_OFS_COUNTER_ONE);
  assign hit_count_two = (haddr[11:0] == SPC_OFS_COUNTER_TWO);
  assign hit_config    = (haddr[11:0] == SPC_OFS_CONFIG);
  assign hit_select    = (haddr[11:0] == SPC_OFS_SELECT);
  assign hit_elapsed   = (haddr[11:0] == SPC_OFS_ELAPSED);

  assign rd_data = hit_count_one ? counts[0]
                 : hit_count_two ? counts[1]
                 : hit_config    ? config_reg
                 : hit_select    ? select_reg
                 : hit_elapsed   ? elapsed
                 : 32'h0000_0000;

  // Data-phase write decode; counters take no writes
  assign wr_config = wr_pend && clk_en && (wr_addr == SPC_OFS_CONFIG);
  assign wr_select = wr_pend && clk_en && (wr_addr == SPC_OFS_SELECT);

  // Reserved bits are dropped so they read as zero
  assign next_config = hwdata & SPC_CONFIG_MASK;
  assign next_select = hwdata & SPC_SELECT_MASK;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hrdata  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      wr_pend <= accept && hwrite;
      if (accept)
        wr_addr <= haddr[11:0];
      if (accept && !hwrite)
        hrdata <= rd_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      config_reg <= SPC_CONFIG_RESET;
      select_reg <= SPC_SELECT_RESET;
    end
    else
    begin
      if (wr_config)
        config_reg <= next_config;
      if (wr_select)
        select_reg <= next_select;
    end
  end

endmodule : spc_perf_counters

// ### logic/spc_pkg.sv
// Shared constants and types of the SDRAM performance counter unit
package spc_pkg;

  localparam logic [11:0] SPC_OFS_COUNTER_ONE   = 12'h000;
  localparam logic [11:0] SPC_OFS_COUNTER_TWO   = 12'h004;
  localparam logic [11:0] SPC_OFS_CONFIG        = 12'h008;
  localparam logic [11:0] SPC_OFS_SELECT        = 12'h00C;
  localparam logic [11:0] SPC_OFS_ELAPSED       = 12'h010;

  localparam int          SPC_CH_STRIDE         = 16;
  localparam int          SPC_CFG_MST_EN_POS    = 15;
  localparam int          SPC_CFG_REG_EN_POS    = 14;
  localparam int          SPC_CFG_TYPE_POS      = 0;
  localparam int          SPC_SEL_MST_POS       = 8;
  localparam int          SPC_SEL_REG_POS       = 0;

  localparam logic [31:0] SPC_CONFIG_MASK       = 32'hC00F_C00F;
  localparam logic [31:0] SPC_SELECT_MASK       = 32'hFF0F_FF0F;
  localparam logic [31:0] SPC_CONFIG_RESET      = 32'h0001_0000;
  localparam logic [31:0] SPC_SELECT_RESET      = 32'h0000_0000;
  localparam logic [31:0] SPC_COUNT_RESET       = 32'h0000_0000;

  localparam logic [3:0]  SPC_REGION_SDRAM      = 4'h0;
  localparam logic [3:0]  SPC_REGION_REGS       = 4'h7;

  typedef enum logic [3:0] {
    SPC_EV_ACCESS   = 4'b0000,
    SPC_EV_ACTIVATE = 4'b0001,
    SPC_EV_READ     = 4'b0010,
    SPC_EV_WRITE    = 4'b0011,
    SPC_EV_QFULL    = 4'b0100,
    SPC_EV_ELEVATE  = 4'b1000,
    SPC_EV_PENDING  = 4'b1001
  } spc_event_e;

  typedef struct packed {
    logic        cmd_valid;
    logic        cmd_write;
    logic [7:0]  cmd_master;
    logic        cmd_to_regs;
    logic [15:0] cmd_bytes;
    logic        activate;
    logic        queue_full;
    logic        queue_pending;
    logic        elevate;
    logic [7:0]  elevate_master;
    logic        elevate_to_regs;
  } spc_events_s;

  typedef struct packed {
    logic        master_en;
    logic        region_en;
    logic [3:0]  event_type;
    logic [7:0]  master_id;
    logic [3:0]  region_sel;
  } spc_chan_cfg_s;

endpackage : spc_pkg

// ### tb/spc_monitor.sv
// Port checker of the performance counter unit
`timescale 1ns/1ps
module spc_monitor
  import spc_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire spc_events_s events
);
  default clocking mon_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic rd_go = hsel && htrans[1] && hready && clk_en && !hwrite;
  sequence rd(logic [11:0] a);
    rd_go && haddr[11:0] == a;
  endsequence
  sequence quiet;
    events == '0;
  endsequence
  ready_follows_a: assert property (hreadyout == clk_en)
    else $error("hreadyout differs from clk_en");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response is not OKAY");
  elapsed_step_a: assert property (
    rd(SPC_OFS_ELAPSED) ##1 clk_en ##1 rd(SPC_OFS_ELAPSED)
    |=> hrdata == $past(hrdata, 2) + 32'h0000_0002)
    else $error("elapsed count skipped");
  read_hold_a: assert property (!rd_go |=> $stable(hrdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (
    rd_go && haddr[11:0] > SPC_OFS_ELAPSED |=> hrdata == '0)
    else $error("unmapped read not zero");
  cfg_masked_a: assert property (
    rd(SPC_OFS_CONFIG) |=> (hrdata & ~SPC_CONFIG_MASK) == '0)
    else $error("config reserved bits set");
  sel_masked_a: assert property (
    rd(SPC_OFS_SELECT) |=> (hrdata & ~SPC_SELECT_MASK) == '0)
    else $error("select reserved bits set");
  quiet_hold_a: assert property (
    rd(SPC_OFS_COUNTER_ONE) ##0 quiet ##1 quiet ##1
    rd(SPC_OFS_COUNTER_ONE) |=> hrdata == $past(hrdata, 2))
    else $error("counter moved without events");
endmodule : spc_monitor

bind spc_perf_counters spc_monitor mon (.hclk, .hresetn, .clk_en, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .events);

// ### tb/spc_partner.sv
// Command path model that feeds events to the counter unit
`timescale 1ns/1ps
module spc_partner
  import spc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        run,
  input  wire spc_events_s want,
  output spc_events_s      events
);
  spc_events_s next_events;

  // A full queue is never empty
  always_comb
  begin
    next_events = run ? want : '0;
    next_events.queue_pending = run && (want.queue_pending | want.queue_full);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      events <= '0;
    else
      events <= next_events;
  end
endmodule : spc_partner

// ### tb/test_spc_perf_counters.sv
// Self-checking bench of the performance counter unit
`timescale 1ns/1ps
module test_spc_perf_counters;
  import spc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        run = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'h2;
  logic [2:0]  burst_log2 = 3'h0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic [31:0] e1 = '0;
  logic [31:0] e2 = '0;
  logic [31:0] el = '0;
  logic [31:0] cw = SPC_CONFIG_RESET;
  logic [31:0] sw = SPC_SELECT_RESET;
  logic [31:0] r;
  logic [31:0] q;
  spc_events_s events;
  spc_events_s want = '0;
  spc_events_s ev;
  integer      seed = 32'h0000_993a;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          t0;

  spc_perf_counters uut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .events, .burst_log2);
  spc_partner far (.hclk, .hresetn, .run, .want, .events);

  always #4 hclk = ~hclk;

  function automatic spc_chan_cfg_s chan(logic [31:0] c, s, int k);
    chan = {c[15+16*k], c[14+16*k], c[16*k+:4], s[16*k+8+:8], s[16*k+:4]};
  endfunction : chan

  function automatic logic [31:0] inc(spc_chan_cfg_s c, spc_events_s e);
    logic el;
    logic m;
    logic r;
    logic a;
    logic [16:0] n;
    el = c.event_type == SPC_EV_ELEVATE;
    m = !c.master_en
        || c.master_id == (el ? e.elevate_master : e.cmd_master);
    r = el ? e.elevate_to_regs : e.cmd_to_regs;
    r = !c.region_en
        || c.region_sel == (r ? SPC_REGION_REGS : SPC_REGION_SDRAM);
    a = !c.master_en && !c.region_en;
    n = ({1'b0, e.cmd_bytes} + (17'h1 << burst_log2) - 17'h1) >> burst_log2;
    case (c.event_type)
      SPC_EV_ACCESS: inc = e.cmd_valid && m && !c.region_en ? n : '0;
      SPC_EV_ACTIVATE: inc = e.activate && a;
      SPC_EV_READ: inc = e.cmd_valid && !e.cmd_write && m && r ? n : '0;
      SPC_EV_WRITE: inc = e.cmd_valid && e.cmd_write && m && r ? n : '0;
      SPC_EV_QFULL: inc = e.queue_full && a;
      SPC_EV_ELEVATE: inc = e.elevate && m && r;
      SPC_EV_PENDING: inc = e.queue_pending && a;
      default: inc = '0;
    endcase
  endfunction : inc

  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (!hresetn)
    begin
      e1 <= '0;
      e2 <= '0;
      el <= '0;
    end
    else if (clk_en)
    begin
      e1 <= e1 + inc(chan(cw, sw, 0), events);
      e2 <= e2 + inc(chan(cw, sw, 1), events);
      el <= el + 32'h0000_0001;
    end
  end

  task automatic chk(input logic [31:0] s, x, input string n);
    num_checks++;
    if (s !== x)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  initial
  begin
    #100000;
    error_cnt++;
    summarize();
  end

  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, SPC_OFS_CONFIG, '0, r);
    chk(r, SPC_CONFIG_RESET, "config reset");
    xfer(1'b0, SPC_OFS_SELECT, '0, r);
    chk(r, SPC_SELECT_RESET, "select reset");
    xfer(1'b0, SPC_OFS_ELAPSED, '0, q);
    t0 = cyc;
    xfer(1'b0, SPC_OFS_ELAPSED, '0, r);
    chk(r - q, cyc - t0, "elapsed step");
    for (int k = 0; k < 32; k++)
    begin
      cw = $random(seed) & SPC_CONFIG_MASK;
      cw[3:0] = k[3:0];
      cw[15:14] = k[4] ? 2'b00 : cw[15:14];
      sw = $random(seed) & SPC_SELECT_MASK & 32'h03FF_03FF;
      sw[2:0] = {3{sw[2]}};
      sw[18:16] = {3{sw[18]}};
      burst_log2 <= 3'($random(seed));
      xfer(1'b1, SPC_OFS_CONFIG, cw, r);
      xfer(1'b1, SPC_OFS_SELECT, sw, r);
      xfer(1'b0, SPC_OFS_CONFIG, '0, r);
      chk(r, cw & SPC_CONFIG_MASK, "config");
      xfer(1'b0, SPC_OFS_SELECT, '0, r);
      chk(r, sw & SPC_SELECT_MASK, "select");
      repeat (40)
      begin
        ev = 40'({$random(seed), $random(seed)});
        ev.cmd_master[7:2] = '0;
        ev.elevate_master[7:2] = '0;
        ev.cmd_bytes[15:9] = '0;
        want <= ev;
        run <= 1'($random(seed));
        clk_en <= 1'($random(seed));
        @(posedge hclk);
      end
      run <= 1'b0;
      clk_en <= 1'b1;
      repeat (2) @(posedge hclk);
      xfer(1'b1, SPC_OFS_COUNTER_ONE, $random(seed), r);
      xfer(1'b1, 12'h014, $random(seed), r);
      xfer(1'b0, 12'h014, '0, r);
      chk(r, '0, "unmapped read");
      repeat (2)
      begin
        xfer(1'b0, SPC_OFS_COUNTER_ONE, '0, r);
        chk(r, e1, "counter one");
      end
      xfer(1'b0, SPC_OFS_COUNTER_TWO, '0, r);
      chk(r, e2, "counter two");
      // Read shows the count before the edge that took the address
      xfer(1'b0, SPC_OFS_ELAPSED, '0, r);
      chk(r, el - 32'h0000_0001, "elapsed");
    end
    // Reset in mid run clears counters and restores the settings
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    cw = SPC_CONFIG_RESET;
    sw = SPC_SELECT_RESET;
    @(posedge hclk);
    xfer(1'b0, SPC_OFS_CONFIG, '0, r);
    chk(r, SPC_CONFIG_RESET, "config after reset");
    xfer(1'b0, SPC_OFS_COUNTER_ONE, '0, r);
    chk(r, SPC_COUNT_RESET, "counter one after reset");
    xfer(1'b0, SPC_OFS_COUNTER_TWO, '0, r);
    chk(r, SPC_COUNT_RESET, "counter two after reset");
    xfer(1'b0, SPC_OFS_ELAPSED, '0, r);
    chk(r, el - 32'h0000_0001, "elapsed after reset");
    summarize();
  end
endmodule : test_spc_perf_counters
